//--- design/pcc_pkg.sv
// Constants shared by the program cache controller and its bench.
// Assumes one 25 MHz clock and a fixed, build-time memory layout.
package pcc_pkg;
    // Register byte addresses.
    localparam logic [31:0] PCC_OFF_CFG = 32'h0184_0020;
    localparam logic [31:0] PCC_OFF_CC = 32'h0184_0024;
    localparam logic [31:0] PCC_OFF_IBAR = 32'h0184_4020;
    localparam logic [31:0] PCC_OFF_IWC = 32'h0184_4024;
    localparam logic [31:0] PCC_OFF_INV = 32'h0184_5028;
    // Cache size select field of the configuration register.
    localparam int PCC_MODE_LSB = 0;
    localparam int PCC_MODE_W = 3;
    // Reset value: the implementation starts with maximal cache.
    localparam logic [2:0] PCC_MODE_RST = 3'h7;
    localparam logic [31:0] PCC_REG_RST = 32'h0000_0000;
    // Program memory layout, fixed when the chip is built.
    localparam logic [31:0] PCC_PM_BASE = 32'h00E0_0000;
    localparam logic [31:0] PCC_R0_BYTES = 32'h0000_8000;
    localparam logic [31:0] PCC_R1_BYTES = 32'h0000_8000;
    localparam logic [31:0] PCC_PM_BYTES = 32'h0001_0000;
    localparam int PCC_RAM_WORDS = 16384;
    localparam int PCC_WADDR_W = 14;
    // Protection page size is a sixteenth of each region.
    localparam int PCC_R0_PAGE_SH = 11;
    localparam int PCC_R1_PAGE_SH = 11;
    localparam logic [4:0] PCC_R1_PAGE0 = 5'h10;
    // Wait states of each region.
    localparam logic [1:0] PCC_WS_R0 = 2'h0;
    localparam logic [1:0] PCC_WS_R1 = 2'h1;
    localparam logic [1:0] PCC_WS_MAX = 2'h3;
    // Cache geometry: 32-byte lines, set index of 7 to 10 bits.
    localparam int PCC_OFS_W = 5;
    localparam int PCC_BEATS = 8;
    localparam int PCC_NLINES = 1024;
    localparam logic [3:0] PCC_IBITS_4K = 4'h7;
    localparam logic [3:0] PCC_IBITS_32K = 4'hA;
    // Largest power of two in region 1, capped at 32K.
    localparam logic [3:0] PCC_IBITS_MAX = 4'hA;
    // Requester codes on the memory access port.
    localparam logic [1:0] PCC_SRC_CPU = 2'h0;
    localparam logic [1:0] PCC_SRC_SDMA = 2'h1;
    localparam logic [1:0] PCC_SRC_INTERNAL_DMA = 2'h2;
    typedef enum logic [2:0] {
        PCC_IDLE, PCC_RAMW, PCC_LOOK, PCC_FILL, PCC_INVAL
    } pcc_state_e;
endpackage

//--- design/pcc_top.sv
// Level-1 program memory with a run-time sized direct-mapped cache.
// Assumes a CPU fetch unit, a level-2 controller that returns eight
// 32-bit beats per line, and DMA masters on the memory access port.
//
// Overview of operation
// - Program memory at most 1MB, regions 512K.
// - Base on 1MB boundary, size 16K multiple.
// - Region 0 power of two, region 1 follows.
// - Pages 0-15 region 0, 16-31 region 1.
// - Only DMA reads or writes program memory.
// - Fixed per-region wait states, three at most.
// - Cache 4K-32K taken from top of region 1.
// - Reset comes up with maximal cache.
// - Direct mapped, 32-byte lines, offset ignored.
// - Index width follows configured cache size.
// - Valid matching tag hits, else go level 2.
// - Allocation overwrites the indexed line.
// - Allocate on read miss, whole line fetched.
// - Small region 1 maps codes 3-7 to 16K.
// - Cache capped at 32K and power of two.
// - Mode change invalidates every cache line.
// - Configuration read-back answers in one cycle, even mid-sweep.
// - Program memory itself is never cached.
`timescale 1ns/1ps
module pcc_top (
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Register port.
    input wire logic [31:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    output logic cpu_stall,
    // CPU instruction fetch.
    input wire logic fetch_req,
    input wire logic [31:0] fetch_addr,
    output logic fetch_ready,
    output logic fetch_done,
    output logic [31:0] fetch_data,
    output logic [4:0] fetch_page,
    // Level-2 line fill.
    output logic l2_req,
    output logic [31:0] l2_addr,
    input wire logic l2_valid,
    input wire logic [31:0] l2_rdata,
    // Memory access port for DMA masters.
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [1:0] mem_src,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_wdata,
    output logic mem_ack,
    output logic mem_err,
    output logic [31:0] mem_rdata
);
    import pcc_pkg::*;

    typedef struct packed {
        pcc_state_e st;
        logic [9:0] cnt;
        logic [2:0] beat;
        logic [31:0] addr;
        logic [2:0] mode;
        logic pend;
        logic on;
        logic [3:0] ibits;
        logic [31:0] ctl;
        logic [31:0] ibar;
        logic [31:0] iwc;
        logic [31:0] inv;
        logic [31:0] rdata;
        logic stall;
        logic ready;
        logic done;
        logic [31:0] fdata;
        logic [4:0] page;
        logic l2req;
        logic [31:0] l2a;
        logic ack;
        logic err;
        logic [31:0] mdata;
    } pcc_s;

    pcc_s s;
    pcc_s next_s;
    logic [31:0] mem [PCC_RAM_WORDS];
    logic [26:0] tag [PCC_NLINES];
    logic [PCC_NLINES-1:0] valid;
    logic [PCC_NLINES-1:0] next_valid;
    logic fill_we;
    logic [PCC_WADDR_W-1:0] fill_idx;
    logic tag_we;
    logic [9:0] set;
    logic [26:0] tag_now;
    logic [31:0] cache_bytes;
    logic [31:0] pm_ofs;
    logic in_pm;
    logic [PCC_WADDR_W-1:0] cbase;
    logic [PCC_WADDR_W-1:0] hit_idx;
    logic [31:0] m_ofs;
    logic m_in;
    logic [1:0] pm_ws;
    logic [31:0] pm_word;

    // Effective index width for a size code, clipped to memory.
    function automatic logic [3:0] pcc_ibits(input logic [2:0] m);
        logic [3:0] b;
        b = (m[2]) ? PCC_IBITS_32K : (PCC_IBITS_4K + {2'h0, m[1:0]} - 4'h1);
        if (b > PCC_IBITS_MAX) begin
            b = PCC_IBITS_MAX;
        end
        return b;
    endfunction

    // Cache occupies the top of region 1 only.
    assign cache_bytes = s.on ? (32'h1 << (s.ibits + 4'h5)) : 32'h0;
    assign cbase = PCC_WADDR_W'((PCC_PM_BYTES - cache_bytes) >> 2);
    assign pm_ofs = s.addr - PCC_PM_BASE;
    assign in_pm = (s.addr[31:20] == PCC_PM_BASE[31:20]) &&
        (pm_ofs < PCC_PM_BYTES);
    // Set and tag split moves with the cache size.
    assign set = 10'(s.addr[31:PCC_OFS_W] &
        ((27'h1 << s.ibits) - 27'h1));
    assign tag_now = s.addr[31:PCC_OFS_W] >> s.ibits;
    assign hit_idx = cbase + PCC_WADDR_W'({set, s.addr[4:2]});
    assign m_ofs = mem_addr - PCC_PM_BASE;
    assign m_in = (mem_addr[31:20] == PCC_PM_BASE[31:20]) &&
        (m_ofs < PCC_PM_BYTES);
    // Region wait states are fixed when the chip is built.
    assign pm_ws = (pm_ofs < PCC_R0_BYTES) ? PCC_WS_R0 : PCC_WS_R1;
    // Words that became cache read as zero.
    assign pm_word = (pm_ofs < PCC_PM_BYTES - cache_bytes) ?
        mem[pm_ofs[PCC_WADDR_W+1:2]] : 32'h0;

    always_comb begin
        next_s = s;
        next_valid = valid;
        fill_we = 1'b0;
        tag_we = 1'b0;
        fill_idx = cbase + PCC_WADDR_W'({set, s.beat});
        next_s.done = 1'b0;
        next_s.ack = 1'b0;
        next_s.err = 1'b0;
        next_s.rdata = 32'h0;
        // Register port: one-cycle reads, unmapped reads give zero.
        if (reg_wr) begin
            unique case (reg_addr)
                PCC_OFF_CFG: begin
                    next_s.mode = reg_wdata[PCC_MODE_LSB+:PCC_MODE_W];
                    next_s.pend = 1'b1;
                end
                PCC_OFF_CC: next_s.ctl = reg_wdata;
                PCC_OFF_IBAR: next_s.ibar = reg_wdata;
                PCC_OFF_IWC: next_s.iwc = reg_wdata;
                PCC_OFF_INV: next_s.inv = reg_wdata;
                default: ;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                PCC_OFF_CFG: next_s.rdata = {29'h0, s.mode};
                PCC_OFF_CC: next_s.rdata = s.ctl;
                PCC_OFF_IBAR: next_s.rdata = s.ibar;
                PCC_OFF_IWC: next_s.rdata = s.iwc;
                PCC_OFF_INV: next_s.rdata = s.inv;
                default: next_s.rdata = 32'h0;
            endcase
        end
        // DMA port; CPU-sourced data accesses are refused.
        if (mem_req) begin
            if (mem_src == PCC_SRC_CPU || !m_in) begin
                next_s.err = 1'b1;
            end else begin
                next_s.ack = 1'b1;
                next_s.mdata = mem[m_ofs[PCC_WADDR_W+1:2]];
            end
        end
        unique case (s.st)
            PCC_IDLE: begin
                if (s.pend) begin
                    // The split changes only once fetches are idle.
                    next_s.pend = reg_wr && reg_addr == PCC_OFF_CFG;
                    next_s.on = s.mode != 3'h0;
                    next_s.ibits = pcc_ibits(s.mode);
                    next_s.cnt = 10'h0;
                    next_s.st = PCC_INVAL;
                end else if (fetch_req && s.ready) begin
                    next_s.addr = fetch_addr;
                    next_s.st = PCC_LOOK;
                    next_s.cnt = 10'h0;
                end
            end
            PCC_LOOK: begin
                if (in_pm) begin
                    // Program memory is served directly, never cached.
                    next_s.page = (pm_ofs < PCC_R0_BYTES) ?
                        5'(pm_ofs >> PCC_R0_PAGE_SH) :
                        PCC_R1_PAGE0 + 5'((pm_ofs - PCC_R0_BYTES) >>
                        PCC_R1_PAGE_SH);
                    // A zero-wait region answers as fast as a hit.
                    if (pm_ws == 2'h0) begin
                        next_s.fdata = pm_word;
                        next_s.done = 1'b1;
                        next_s.st = PCC_IDLE;
                    end else begin
                        next_s.cnt = {8'h0, pm_ws - 2'h1};
                        next_s.st = PCC_RAMW;
                    end
                end else if (s.on && valid[set] && tag[set] == tag_now) begin
                    next_s.fdata = mem[hit_idx];
                    next_s.done = 1'b1;
                    next_s.st = PCC_IDLE;
                end else begin
                    next_s.l2req = 1'b1;
                    next_s.l2a = {s.addr[31:PCC_OFS_W], 5'h0};
                    next_s.beat = 3'h0;
                    next_s.st = PCC_FILL;
                end
            end
            PCC_RAMW: begin
                if (s.cnt[1:0] == 2'h0) begin
                    next_s.fdata = pm_word;
                    next_s.done = 1'b1;
                    next_s.st = PCC_IDLE;
                end else begin
                    next_s.cnt = s.cnt - 10'h1;
                end
            end
            PCC_FILL: begin
                next_s.l2req = 1'b0;
                if (l2_valid) begin
                    fill_we = s.on;
                    if (s.beat == s.addr[4:2]) begin
                        next_s.fdata = l2_rdata;
                    end
                    next_s.beat = s.beat + 3'h1;
                    if (s.beat == 3'(PCC_BEATS - 1)) begin
                        next_valid[set] = s.on;
                        tag_we = s.on;
                        next_s.done = 1'b1;
                        next_s.st = PCC_IDLE;
                    end
                end
            end
            PCC_INVAL: begin
                next_valid[s.cnt] = 1'b0;
                next_s.cnt = s.cnt + 10'h1;
                if (s.cnt == 10'(PCC_NLINES - 1)) begin
                    next_s.st = PCC_IDLE;
                end
            end
        endcase
        // Stall covers the pending write and the sweep.
        next_s.stall = next_s.pend || next_s.st == PCC_INVAL;
        next_s.ready = next_s.st == PCC_IDLE && !next_s.stall &&
            !(s.st == PCC_IDLE && fetch_req && s.ready);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s <= '0;
            s.st <= PCC_INVAL;
            s.mode <= PCC_MODE_RST;
            s.on <= 1'b1;
            s.ibits <= PCC_IBITS_MAX;
            s.stall <= 1'b1;
            s.ctl <= PCC_REG_RST;
            valid <= '0;
        end else begin
            s <= next_s;
            valid <= next_valid;
        end
    end

    // Storage arrays carry no reset; valid bits guard the cache part.
    always_ff @(posedge clk) begin
        if (fill_we) begin
            mem[fill_idx] <= l2_rdata;
        end
        if (mem_req && mem_we && mem_src != PCC_SRC_CPU && m_in) begin
            mem[m_ofs[PCC_WADDR_W+1:2]] <= mem_wdata;
        end
        if (tag_we) begin
            tag[set] <= tag_now;
        end
    end

    assign reg_rdata = s.rdata;
    assign cpu_stall = s.stall;
    assign fetch_ready = s.ready;
    assign fetch_done = s.done;
    assign fetch_data = s.fdata;
    assign fetch_page = s.page;
    assign l2_req = s.l2req;
    assign l2_addr = s.l2a;
    assign mem_ack = s.ack;
    assign mem_err = s.err;
    assign mem_rdata = s.mdata;

    default clocking pcc_cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence cfg_write_seq;
        reg_wr && reg_addr == PCC_OFF_CFG;
    endsequence
    sequence sweep_seq;
        s.st == PCC_INVAL;
    endsequence

    a_cpu_refused: assert property (
        mem_req && mem_src == PCC_SRC_CPU |=> mem_err && !mem_ack)
        else $error("CPU data access not refused");
    a_mode_invalidates: assert property (
        cfg_write_seq |-> ##[1:40] sweep_seq)
        else $error("mode write did not start invalidation");
    a_stall_on_cfg: assert property (
        cfg_write_seq |=> cpu_stall)
        else $error("no stall after mode write");
    a_no_fetch_sweep: assert property (
        sweep_seq |-> !fetch_ready && !fetch_done)
        else $error("fetch served during invalidation");
    a_sweep_clears: assert property (
        s.st == PCC_INVAL && s.cnt == 10'h3FF |=> valid == '0)
        else $error("lines left valid after sweep");
    a_cap_size: assert property (
        s.on |-> s.ibits <= PCC_IBITS_MAX && s.ibits >= PCC_IBITS_4K)
        else $error("cache size out of range");
    a_ws_bound: assert property (
        s.st == PCC_LOOK && in_pm |=> ##[0:3] fetch_done)
        else $error("wait count above three");
    a_miss_to_l2: assert property (
        s.st == PCC_LOOK && !in_pm && !(s.on && valid[set] &&
        tag[set] == tag_now) |=> l2_req ##1 !l2_req)
        else $error("miss not forwarded");
    a_pm_uncached: assert property (
        s.st == PCC_LOOK && in_pm |=> !l2_req)
        else $error("program memory sent to level two");
    a_fill_valid: assert property (
        s.st == PCC_FILL && l2_valid && s.beat == 3'h7 && s.on |=>
        valid[$past(set)] && fetch_done)
        else $error("line not allocated after fill");
endmodule // pcc_top

//--- test/pcc_l2_model.sv
// Level-2 line-fill responder standing behind the program cache.
// Assumes one-cycle line requests that carry a 32-byte-aligned address.
`timescale 1ns/1ps
module pcc_l2_model (
    // Clock.
    input wire logic clk,
    // Line request from the cache.
    input wire logic l2_req,
    input wire logic [31:0] l2_addr,
    // Returned beats.
    output logic l2_valid,
    output logic [31:0] l2_rdata
);
    // Data is inverted in each gap cycle and after the last beat so a stale beat never looks valid.
    initial begin
        logic [31:0] base;
        int g;
        l2_valid = 1'b0;
        l2_rdata = 32'h0;
        forever begin
            @(posedge clk);
            if (l2_req === 1'b1) begin
                base = {l2_addr[31:5], 5'h00};
                for (int b = 0; b < 8; b++) begin
                    g = $urandom_range(0, 2);
                    repeat (g) begin
                        l2_valid <= 1'b0;
                        l2_rdata <= ~l2_rdata;
                        @(posedge clk);
                    end
                    l2_valid <= 1'b1;
                    l2_rdata <= (base + 32'(b * 4)) ^ 32'h5A5A_C3C3;
                    @(posedge clk);
                end
                l2_valid <= 1'b0;
                l2_rdata <= ~l2_rdata;
            end
        end
    end
endmodule // pcc_l2_model

//--- test/tb.sv
// Self-checking bench for the program cache controller.
// Assumes the level-2 responder model and the shared constants package.
`timescale 1ns/1ps
module tb;
    import pcc_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr = 1'b0, reg_rd = 1'b0, fetch_req = 1'b0;
    logic mem_req = 1'b0, mem_we = 1'b0;
    logic [31:0] reg_addr = '0, reg_wdata = '0, fetch_addr = '0;
    logic [31:0] mem_addr = '0, mem_wdata = '0;
    logic [1:0] mem_src = '0;
    logic [31:0] reg_rdata, fetch_data, l2_addr, l2_rdata, mem_rdata;
    logic cpu_stall, fetch_ready, fetch_done, l2_req, l2_valid;
    logic mem_ack, mem_err;
    logic [4:0] fetch_page;
    int num_errors = 0, comparisons = 0, l2_cnt = 0;

    always #20 clk = ~clk;
    always @(posedge clk) if (l2_req === 1'b1) l2_cnt <= l2_cnt + 1;

    pcc_top i_dut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .cpu_stall, .fetch_req, .fetch_addr, .fetch_ready,
        .fetch_done, .fetch_data, .fetch_page, .l2_req, .l2_addr,
        .l2_valid, .l2_rdata, .mem_req, .mem_we, .mem_src, .mem_addr,
        .mem_wdata, .mem_ack, .mem_err, .mem_rdata);
    pcc_l2_model i_l2 (.clk, .l2_req, .l2_addr, .l2_valid, .l2_rdata);

    function automatic logic [31:0] l2_word(input logic [31:0] a);
        return {a[31:2], 2'h0} ^ 32'h5A5A_C3C3;
    endfunction
    function automatic int ibits(input int m);
        return (m == 0) ? 0 : (m < 4) ? m + 6 : int'(PCC_IBITS_MAX);
    endfunction

    task final_report;
        if (num_errors == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task rw(input logic [31:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task rr(input logic [31:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        d = reg_rdata;
    endtask
    task dma(input logic [1:0] s, input logic we, input logic [31:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic er);
        @(posedge clk);
        mem_req <= 1'b1;
        mem_src <= s;
        mem_we <= we;
        mem_addr <= a;
        mem_wdata <= d;
        @(posedge clk);
        mem_req <= 1'b0;
        @(negedge clk);
        q = mem_rdata;
        er = mem_err;
        chk({31'h0, mem_ack}, {31'h0, ~er});
    endtask
    task fetch(input logic [31:0] a, output logic [31:0] q, output int n);
        for (int k = 0; k < 2000 && fetch_ready !== 1'b1; k++) @(negedge clk);
        @(posedge clk);
        fetch_req <= 1'b1;
        fetch_addr <= a;
        @(posedge clk);
        fetch_req <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (fetch_done !== 1'b1 && n < 2000);
        q = fetch_data;
    endtask
    task cfetch(input logic [31:0] a, input logic miss);
        int c, n;
        logic [31:0] q;
        c = l2_cnt;
        fetch(a, q, n);
        chk(q, l2_word(a));
        chk(32'(l2_cnt - c), {31'h0, miss});
        if (miss) chk(l2_addr, {a[31:5], 5'h00});
        else chk(32'(n), 32'h2);
    endtask
    // The read-back goes out while the sweep still runs, as software would.
    task mode(input logic [2:0] m);
        int n, bad;
        logic [31:0] q;
        for (int k = 0; k < 2000 && cpu_stall !== 1'b0; k++) @(negedge clk);
        rw(PCC_OFF_CFG, {29'h0, m});
        rr(PCC_OFF_CFG, q);
        chk(q, {29'h0, m});
        n = 2;
        bad = 0;
        while (cpu_stall !== 1'b0 && n < 1200) begin
            if (fetch_ready !== 1'b0) bad++;
            @(negedge clk);
            n++;
        end
        chk(32'(bad), 32'h0);
        chk(32'(n >= 1020 && n < 1100), 32'h1);
    endtask

    initial begin
        repeat (40000) @(posedge clk);
        num_errors++;
        final_report;
    end

    initial begin
        logic [31:0] offs [4];
        logic [31:0] q, d, a, r0, r1;
        logic er;
        int n, ib, c;
        offs = '{PCC_OFF_CC, PCC_OFF_IBAR, PCC_OFF_IWC, PCC_OFF_INV};
        void'($urandom(32'h8C8A_4C6B));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        rr(PCC_OFF_CFG, q);
        chk(q, {29'h0, PCC_MODE_RST});
        foreach (offs[i]) begin
            d = $urandom;
            rr(offs[i], q);
            chk(q, PCC_REG_RST);
            rw(offs[i], d);
            rr(offs[i], q);
            chk(q, d);
        end
        rw(32'h0184_0028, $urandom);
        rr(32'h0184_0028, q);
        chk(q, 32'h0);
        a = 32'h8000_0000 | ($urandom & 32'h7FFF_FFE0);
        for (int m = 0; m < 8; m++) begin
            mode(3'(m));
            ib = ibits(m);
            cfetch(a, 1'b1);
            if (m == 0) begin
                cfetch(a, 1'b1);
            end else begin
                cfetch(a + (32'($urandom_range(1, 7)) << 2), 1'b0);
                cfetch(a + (32'h20 << (ib - 1)), 1'b1);
                cfetch(a, 1'b0);
                cfetch(a + (32'h20 << ib), 1'b1);
                cfetch(a, 1'b1);
            end
        end
        mode(3'h1);
        r1 = PCC_PM_BASE + PCC_R0_BYTES + PCC_R1_BYTES - 32'h1004;
        d = $urandom;
        dma(PCC_SRC_SDMA, 1'b1, r1, d, q, er);
        fetch(r1, q, n);
        chk(q, d);
        chk(32'(n), 32'(2 + PCC_WS_R1));
        chk({27'h0, fetch_page}, 32'(PCC_R1_PAGE0)
            + ((r1 - PCC_PM_BASE - PCC_R0_BYTES) >> PCC_R1_PAGE_SH));
        fetch(r1 + 32'h4, q, n);
        chk(q, 32'h0);
        r0 = PCC_PM_BASE + (32'($urandom_range(0, 8191)) << 2);
        d = $urandom;
        c = l2_cnt;
        dma(PCC_SRC_INTERNAL_DMA, 1'b1, r0, d, q, er);
        fetch(r0, q, n);
        chk(q, d);
        chk(32'(n), 32'(2 + PCC_WS_R0));
        chk({27'h0, fetch_page}, (r0 - PCC_PM_BASE) >> PCC_R0_PAGE_SH);
        chk(32'(l2_cnt - c), 32'h0);
        dma(PCC_SRC_CPU, 1'b1, r0, ~d, q, er);
        chk({31'h0, er}, 32'h1);
        dma(PCC_SRC_CPU, 1'b0, r0, 32'h0, q, er);
        chk({31'h0, er}, 32'h1);
        dma(PCC_SRC_SDMA, 1'b0, r0, 32'h0, q, er);
        chk(q, d);
        dma(PCC_SRC_SDMA, 1'b0, PCC_PM_BASE + PCC_PM_BYTES, 32'h0, q, er);
        chk({31'h0, er}, 32'h1);
        final_report;
    end
endmodule // tb
